// file: inc/fifo_host_pkg.sv
package fifo_host_pkg;

  localparam int CLK_NS = 25;
  localparam int SYNC_CYC = 2;

  // timing figures in ns
  localparam int T_WPW_NS = 35;
  localparam int T_WR_NS = 10;
  localparam int T_RPW_NS = 35;
  localparam int T_RR_NS = 10;
  localparam int T_RS_NS = 35;
  localparam int T_RSR_NS = 10;

  // least time to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] WPW_CYC = 4'(cyc_up(T_WPW_NS));
  localparam logic [3:0] WR_CYC = 4'(cyc_up(T_WR_NS));
  localparam logic [3:0] RPW_CYC = 4'(cyc_up(T_RPW_NS) + SYNC_CYC);
  localparam logic [3:0] RR_CYC = 4'(cyc_up(T_RR_NS));
  localparam logic [3:0] RS_CYC = 4'(cyc_up(T_RS_NS));
  localparam logic [3:0] RSR_CYC = 4'(cyc_up(T_RSR_NS));
  localparam logic [3:0] SER_HALF_CYC = 4'h2;
  localparam logic [3:0] SER_LO_CYC = 4'(int'(SER_HALF_CYC) + SYNC_CYC);

  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_WDATA = 8'h08;
  localparam logic [7:0] ADDR_RDATA = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // control fields
  localparam int CTRL_IN_PAR = 0;
  localparam int CTRL_OUT_PAR = 1;
  localparam int CTRL_RT = 2;
  localparam int CTRL_WID_LO = 4;
  localparam logic [3:0] WID_RESET = 4'h9;

  // command fields
  localparam int CMD_WR = 0;
  localparam int CMD_RD = 1;
  localparam int CMD_RS = 2;

  // status fields
  localparam int ST_BUSY = 6;
  localparam int ST_REFUSED = 7;
  localparam int ST_DBUS_LO = 16;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RS_LO = 4'h1,
    S_RS_REC = 4'h2,
    S_WR_LO = 4'h3,
    S_WR_REC = 4'h4,
    S_RD_LO = 4'h5,
    S_RD_REC = 4'h6,
    S_SI_LO = 4'h7,
    S_SI_HI = 4'h8,
    S_SO_HI = 4'h9,
    S_SO_LO = 4'ha
  } state_type;

endpackage

// file: rtl/sync_bank.sv
`timescale 1ns/1ps
module sync_bank #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// file: rtl/fifo_host.sv
`timescale 1ns/1ps
module fifo_host #(
  parameter int DATA_W = 9
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fifo control pins
  output logic fifo_reset_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic output_enable_n,
  output logic input_mode_select,
  output logic output_mode_select,
  output logic first_load_or_retransmit,
  output logic expansion_input,
  output logic serial_input_expansion_pin,
  output logic serial_output_expansion_pin,
  // fifo data pins
  input wire logic [DATA_W-1:0] parallel_input_bus_in,
  output logic [DATA_W-1:0] parallel_input_bus_out,
  output logic [DATA_W-1:0] parallel_input_bus_oe_n,
  input wire logic [DATA_W-1:0] parallel_output_bus,
  output logic serial_input,
  output logic serial_input_clock,
  output logic serial_output_clock,
  input wire logic serial_output,
  // fifo flags, active low
  input wire logic empty_flag,
  input wire logic empty_plus_one_flag,
  input wire logic almost_empty_almost_full_flag,
  input wire logic expansion_out_or_half_full_pin,
  input wire logic full_minus_one_flag,
  input wire logic full_flag
);

  localparam int SW = 2 * DATA_W + 7;

  logic [SW-1:0] pins_s;
  logic [DATA_W-1:0] q_s;
  logic [DATA_W-1:0] d_s;
  logic so_s;
  logic [5:0] flags_s;

  sync_bank #(.W(SW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({parallel_input_bus_in, parallel_output_bus, serial_output, full_flag,
        full_minus_one_flag, expansion_out_or_half_full_pin,
        almost_empty_almost_full_flag, empty_plus_one_flag, empty_flag}),
    .q(pins_s)
  );

  assign flags_s = pins_s[5:0];
  assign so_s = pins_s[6];
  assign q_s = pins_s[DATA_W+6:7];
  assign d_s = pins_s[SW-1:DATA_W+7];

  fifo_host_pkg::state_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [DATA_W-1:0] sh_r, sh_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic in_par_r, in_par_nxt;
  logic out_par_r, out_par_nxt;
  logic rt_r, rt_nxt;
  logic [3:0] wid_r, wid_nxt;
  logic refused_r, refused_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic rs_n_nxt, w_n_nxt, r_n_nxt, si_nxt, sic_nxt, soc_nxt;
  logic [DATA_W-1:0] dout_nxt, doe_n_nxt;

  logic acc_setup, acc_done, busy, hit;
  logic [3:0] last_bit;

  function automatic logic addr_hit(input logic [7:0] a);
    return a == fifo_host_pkg::ADDR_CTRL || a == fifo_host_pkg::ADDR_CMD ||
           a == fifo_host_pkg::ADDR_WDATA || a == fifo_host_pkg::ADDR_RDATA ||
           a == fifo_host_pkg::ADDR_STATUS;
  endfunction

  always_comb begin
    acc_setup = psel & penable & ~pready;
    acc_done = psel & penable & pready;
    busy = st_r != fifo_host_pkg::S_IDLE;
    hit = addr_hit(paddr);
    last_bit = wid_r - 4'h1;
    st_nxt = st_r;
    cnt_nxt = (cnt_r != 4'h0) ? cnt_r - 4'h1 : cnt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    in_par_nxt = in_par_r;
    out_par_nxt = out_par_r;
    rt_nxt = rt_r;
    wid_nxt = wid_r;
    refused_nxt = refused_r;
    rs_n_nxt = fifo_reset_n;
    w_n_nxt = write_strobe_n;
    r_n_nxt = read_strobe_n;
    si_nxt = serial_input;
    sic_nxt = serial_input_clock;
    soc_nxt = serial_output_clock;
    dout_nxt = parallel_input_bus_out;
    doe_n_nxt = parallel_input_bus_oe_n;
    pready_nxt = acc_setup;
    pslverr_nxt = acc_setup & ~hit;
    prdata_nxt = 32'h0000_0000;
    if (acc_setup && !pwrite) begin
      case (paddr)
        fifo_host_pkg::ADDR_CTRL: begin
          prdata_nxt[fifo_host_pkg::CTRL_IN_PAR] = in_par_r;
          prdata_nxt[fifo_host_pkg::CTRL_OUT_PAR] = out_par_r;
          prdata_nxt[fifo_host_pkg::CTRL_RT] = rt_r;
          prdata_nxt[fifo_host_pkg::CTRL_WID_LO +: 4] = wid_r;
        end
        fifo_host_pkg::ADDR_WDATA: prdata_nxt[DATA_W-1:0] = wdata_r;
        fifo_host_pkg::ADDR_RDATA: prdata_nxt[DATA_W-1:0] = rdata_r;
        fifo_host_pkg::ADDR_STATUS: begin
          prdata_nxt[5:0] = flags_s;
          prdata_nxt[fifo_host_pkg::ST_BUSY] = busy;
          prdata_nxt[fifo_host_pkg::ST_REFUSED] = refused_r;
          prdata_nxt[fifo_host_pkg::ST_DBUS_LO +: DATA_W] = d_s;
        end
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    // mode and data registers ignored while a cycle runs
    if (acc_done && pwrite && !busy) begin
      case (paddr)
        fifo_host_pkg::ADDR_CTRL: begin
          in_par_nxt = pwdata[fifo_host_pkg::CTRL_IN_PAR];
          out_par_nxt = pwdata[fifo_host_pkg::CTRL_OUT_PAR];
          rt_nxt = pwdata[fifo_host_pkg::CTRL_RT];
          wid_nxt = pwdata[fifo_host_pkg::CTRL_WID_LO +: 4];
        end
        fifo_host_pkg::ADDR_WDATA: wdata_nxt = pwdata[DATA_W-1:0];
        fifo_host_pkg::ADDR_CMD: begin
          refused_nxt = 1'b0;
          if (pwdata[fifo_host_pkg::CMD_RS]) begin
            rs_n_nxt = 1'b0;
            cnt_nxt = fifo_host_pkg::RS_CYC - 4'h1;
            st_nxt = fifo_host_pkg::S_RS_LO;
          end else if (pwdata[fifo_host_pkg::CMD_WR]) begin
            if (!flags_s[5]) begin
              refused_nxt = 1'b1;
            end else if (in_par_r) begin
              w_n_nxt = 1'b0;
              dout_nxt = wdata_r;
              doe_n_nxt = '0;
              cnt_nxt = fifo_host_pkg::WPW_CYC - 4'h1;
              st_nxt = fifo_host_pkg::S_WR_LO;
            end else begin
              // word shifts out lsb first via the wired serial input pin
              sh_nxt = wdata_r;
              si_nxt = wdata_r[0];
              bit_nxt = 4'h0;
              cnt_nxt = fifo_host_pkg::SER_HALF_CYC - 4'h1;
              st_nxt = fifo_host_pkg::S_SI_LO;
            end
          end else if (pwdata[fifo_host_pkg::CMD_RD]) begin
            if (!flags_s[0]) begin
              refused_nxt = 1'b1;
            end else if (out_par_r) begin
              r_n_nxt = 1'b0;
              cnt_nxt = fifo_host_pkg::RPW_CYC - 4'h1;
              st_nxt = fifo_host_pkg::S_RD_LO;
            end else begin
              // word loads via the wired output pin
              sh_nxt = '0;
              bit_nxt = 4'h0;
              soc_nxt = 1'b1;
              cnt_nxt = fifo_host_pkg::SER_HALF_CYC - 4'h1;
              st_nxt = fifo_host_pkg::S_SO_HI;
            end
          end
        end
        default: ;
      endcase
    end
    case (st_r)
      fifo_host_pkg::S_IDLE: ;
      fifo_host_pkg::S_RS_LO: if (cnt_r == 4'h0) begin
        rs_n_nxt = 1'b1;
        cnt_nxt = fifo_host_pkg::RSR_CYC - 4'h1;
        st_nxt = fifo_host_pkg::S_RS_REC;
      end
      fifo_host_pkg::S_RS_REC: if (cnt_r == 4'h0) begin
        st_nxt = fifo_host_pkg::S_IDLE;
      end
      fifo_host_pkg::S_WR_LO: if (cnt_r == 4'h0) begin
        w_n_nxt = 1'b1;
        cnt_nxt = fifo_host_pkg::WR_CYC - 4'h1;
        st_nxt = fifo_host_pkg::S_WR_REC;
      end
      fifo_host_pkg::S_WR_REC: if (cnt_r == 4'h0) begin
        doe_n_nxt = '1;
        st_nxt = fifo_host_pkg::S_IDLE;
      end
      fifo_host_pkg::S_RD_LO: if (cnt_r == 4'h0) begin
        rdata_nxt = q_s;
        r_n_nxt = 1'b1;
        cnt_nxt = fifo_host_pkg::RR_CYC - 4'h1;
        st_nxt = fifo_host_pkg::S_RD_REC;
      end
      fifo_host_pkg::S_RD_REC: if (cnt_r == 4'h0) begin
        st_nxt = fifo_host_pkg::S_IDLE;
      end
      fifo_host_pkg::S_SI_LO: if (cnt_r == 4'h0) begin
        sic_nxt = 1'b1;
        cnt_nxt = fifo_host_pkg::SER_HALF_CYC - 4'h1;
        st_nxt = fifo_host_pkg::S_SI_HI;
      end
      fifo_host_pkg::S_SI_HI: if (cnt_r == 4'h0) begin
        sic_nxt = 1'b0;
        sh_nxt = sh_r >> 1;
        si_nxt = sh_r[1];
        bit_nxt = bit_r + 4'h1;
        cnt_nxt = fifo_host_pkg::SER_HALF_CYC - 4'h1;
        st_nxt = (bit_r >= last_bit) ? fifo_host_pkg::S_IDLE : fifo_host_pkg::S_SI_LO;
      end
      fifo_host_pkg::S_SO_HI: if (cnt_r == 4'h0) begin
        soc_nxt = 1'b0;
        cnt_nxt = fifo_host_pkg::SER_LO_CYC - 4'h1;
        st_nxt = fifo_host_pkg::S_SO_LO;
      end
      fifo_host_pkg::S_SO_LO: if (cnt_r == 4'h0) begin
        sh_nxt[bit_r] = so_s;
        bit_nxt = bit_r + 4'h1;
        if (bit_r >= last_bit) begin
          rdata_nxt = sh_nxt;
          st_nxt = fifo_host_pkg::S_IDLE;
        end else begin
          soc_nxt = 1'b1;
          cnt_nxt = fifo_host_pkg::SER_HALF_CYC - 4'h1;
          st_nxt = fifo_host_pkg::S_SO_HI;
        end
      end
      default: st_nxt = fifo_host_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= fifo_host_pkg::S_RS_LO;
      cnt_r <= fifo_host_pkg::RS_CYC - 4'h1;
      bit_r <= 4'h0;
      sh_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      in_par_r <= 1'b1;
      out_par_r <= 1'b1;
      rt_r <= 1'b1;
      wid_r <= fifo_host_pkg::WID_RESET;
      refused_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      fifo_reset_n <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      serial_input <= 1'b0;
      serial_input_clock <= 1'b0;
      serial_output_clock <= 1'b0;
      parallel_input_bus_out <= '0;
      parallel_input_bus_oe_n <= '1;
      output_enable_n <= 1'b0;
      input_mode_select <= 1'b1;
      output_mode_select <= 1'b1;
      first_load_or_retransmit <= 1'b1;
      expansion_input <= 1'b0;
      serial_input_expansion_pin <= 1'b1;
      serial_output_expansion_pin <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      in_par_r <= in_par_nxt;
      out_par_r <= out_par_nxt;
      rt_r <= rt_nxt;
      wid_r <= wid_nxt;
      refused_r <= refused_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      fifo_reset_n <= rs_n_nxt;
      write_strobe_n <= w_n_nxt;
      read_strobe_n <= r_n_nxt;
      serial_input <= si_nxt;
      serial_input_clock <= sic_nxt;
      serial_output_clock <= soc_nxt;
      parallel_input_bus_out <= dout_nxt;
      parallel_input_bus_oe_n <= doe_n_nxt;
      output_enable_n <= 1'b0;
      input_mode_select <= in_par_r;
      output_mode_select <= out_par_r;
      first_load_or_retransmit <= rt_r;
      expansion_input <= 1'b0;
      serial_input_expansion_pin <= 1'b1;
      serial_output_expansion_pin <= 1'b1;
    end
  end

endmodule

// file: dv/fifo_host_asserts.sv
`timescale 1ns/1ps
module fifo_host_asserts #(
  parameter int DATA_W = 9
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fifo pins
  input wire logic fifo_reset_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic input_mode_select,
  input wire logic output_mode_select,
  input wire logic expansion_input,
  input wire logic serial_input_expansion_pin,
  input wire logic serial_output_expansion_pin,
  input wire logic [DATA_W-1:0] parallel_input_bus_oe_n,
  input wire logic serial_input,
  input wire logic serial_input_clock,
  input wire logic serial_output_clock,
  input wire logic empty_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_pulse;
    !write_strobe_n [*2] ##1 write_strobe_n;
  endsequence
  sequence s_rd_pulse;
    !read_strobe_n [*4] ##1 read_strobe_n;
  endsequence
  sequence s_si_bit;
    serial_input_clock [*2] ##1 !serial_input_clock;
  endsequence
  sequence s_so_bit;
    serial_output_clock [*2] ##1 !serial_output_clock [*4];
  endsequence
  property p_rst;
    $rose(presetn) |-> !fifo_reset_n ##[1:4] fifo_reset_n;
  endproperty
  property p_single;
    expansion_input == 1'b0;
  endproperty
  property p_xpins;
    serial_input_expansion_pin && serial_output_expansion_pin;
  endproperty
  property p_wr;
    $fell(write_strobe_n) |-> input_mode_select && !(|parallel_input_bus_oe_n) ##0 s_wr_pulse;
  endproperty
  property p_rd;
    $fell(read_strobe_n) |-> output_mode_select ##0 s_rd_pulse;
  endproperty
  property p_no_rd;
    !empty_flag [*4] |=> !$fell(read_strobe_n);
  endproperty
  property p_si;
    $rose(serial_input_clock) |-> $stable(serial_input) && !input_mode_select ##0 s_si_bit;
  endproperty
  property p_so;
    $rose(serial_output_clock) |-> !output_mode_select ##0 s_so_bit;
  endproperty
  property p_rel;
    !input_mode_select |-> &parallel_input_bus_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("fifo reset not run");
  a_single: assert property (p_single) else $error("expansion input high");
  a_xpins: assert property (p_xpins) else $error("expansion pin low");
  a_wr: assert property (p_wr) else $error("bad write strobe");
  a_rd: assert property (p_rd) else $error("bad read strobe");
  a_no_rd: assert property (p_no_rd) else $error("read while empty");
  a_si: assert property (p_si) else $error("bad serial in clock");
  a_so: assert property (p_so) else $error("bad serial out clock");
  a_rel: assert property (p_rel) else $error("data pins driven");
endmodule

bind fifo_host fifo_host_asserts #(.DATA_W(DATA_W)) chk (.*);

// file: dv/fifo_device_model.sv
`timescale 1ns/1ps
module fifo_device_model #(
  parameter int DEPTH = 2048
) (
  // control
  input wire logic fifo_reset_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic output_enable_n,
  input wire logic input_mode_select,
  input wire logic output_mode_select,
  input wire logic expansion_input,
  input wire logic [3:0] ser_width,
  // data
  input wire logic [8:0] parallel_input_bus,
  output logic [8:0] parallel_output_bus,
  input wire logic serial_input,
  input wire logic serial_input_clock,
  input wire logic serial_output_clock,
  output logic serial_output,
  // flags, active low
  output logic empty_flag,
  output logic empty_plus_one_flag,
  output logic almost_empty_almost_full_flag,
  output logic expansion_out_or_half_full_pin,
  output logic full_minus_one_flag,
  output logic full_flag
);
  logic [8:0] mem [DEPTH];
  logic [8:0] q_r = '0;
  logic [8:0] si_sr = '0;
  logic [8:0] so_sr = '0;
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  int si_n = 0;
  int so_n = 0;
  int last_cnt = 0;
  logic xo_n = 1'b1;
  initial serial_output = 1'b0;
  // depth expansion: short low pulse whenever the last location is filled or read
  always @(last_cnt) begin
    xo_n = 1'b0;
    #20 xo_n = 1'b1;
  end
  assign empty_flag = cnt != 0;
  assign empty_plus_one_flag = cnt > 1;
  assign almost_empty_almost_full_flag = cnt > DEPTH / 8 && cnt < DEPTH * 7 / 8;
  assign expansion_out_or_half_full_pin = (expansion_input === 1'b0) ? !(cnt > DEPTH / 2) : xo_n;
  assign full_minus_one_flag = cnt < DEPTH - 1;
  assign full_flag = cnt != DEPTH;
  // disabled outputs drift, never hold the old word
  assign parallel_output_bus = output_enable_n ? ~q_r : q_r;
  function automatic logic [8:0] pop();
    logic [8:0] w;
    w = mem[rp];
    if (rp == DEPTH - 1) last_cnt++;
    rp = (rp + 1) % DEPTH;
    cnt--;
    return w;
  endfunction
  task automatic put(input logic [8:0] w);
    if (cnt < DEPTH) begin
      mem[wp] = w;
      if (wp == DEPTH - 1) last_cnt++;
      wp = (wp + 1) % DEPTH;
      cnt++;
    end
  endtask
  always @(negedge fifo_reset_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    si_n = 0;
    so_n = 0;
  end
  always @(posedge write_strobe_n) begin
    if (fifo_reset_n === 1'b1 && input_mode_select === 1'b1) put(parallel_input_bus);
  end
  always @(negedge read_strobe_n) begin
    if (fifo_reset_n === 1'b1 && output_mode_select === 1'b1 && cnt > 0) q_r = pop();
  end
  always @(posedge serial_input_clock) begin
    if (fifo_reset_n === 1'b1 && input_mode_select === 1'b0) begin
      si_sr[si_n] = serial_input;
      si_n++;
      if (si_n == int'(ser_width)) begin
        put(si_sr);
        si_sr = '0;
        si_n = 0;
      end
    end
  end
  always @(posedge serial_output_clock) begin
    if (fifo_reset_n === 1'b1 && output_mode_select === 1'b0) begin
      if (so_n == 0 && cnt > 0) so_sr = pop();
      serial_output = so_sr[so_n];
      so_n = (so_n + 1 == int'(ser_width)) ? 0 : so_n + 1;
    end
  end
endmodule

// file: dv/fifo_host_bench.sv
`timescale 1ns/1ps
module fifo_host_bench;
  localparam int D = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic fifo_reset_n, write_strobe_n, read_strobe_n, output_enable_n;
  logic input_mode_select, output_mode_select, first_load_or_retransmit;
  logic expansion_input, serial_input_expansion_pin, serial_output_expansion_pin;
  logic [8:0] parallel_input_bus_in, parallel_input_bus_out, parallel_input_bus_oe_n;
  logic [8:0] parallel_input_bus, parallel_output_bus, d_last;
  logic serial_input, serial_input_clock, serial_output_clock, serial_output;
  logic empty_flag, empty_plus_one_flag, almost_empty_almost_full_flag;
  logic expansion_out_or_half_full_pin, full_minus_one_flag, full_flag;
  logic [3:0] ser_width;
  int miscompares, cmp_count;
  // released pins drift away from their last level
  assign parallel_input_bus = (parallel_input_bus_out & ~parallel_input_bus_oe_n)
                            | (~d_last & parallel_input_bus_oe_n);
  assign parallel_input_bus_in = parallel_input_bus;
  always @(posedge pclk) d_last <= parallel_input_bus;
  fifo_host dut (.*);
  fifo_device_model #(.DEPTH(D)) far (.*);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k == 50) miscompares++;
    v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle;
    for (int k = 0; k < 200; k++) begin
      apb(fifo_host_pkg::ADDR_STATUS, 1'b0, 32'h0);
      if (v[fifo_host_pkg::ST_BUSY] === 1'b0) return;
    end
    miscompares++;
  endtask
  task automatic cmd(input int b);
    apb(fifo_host_pkg::ADDR_CMD, 1'b1, 32'(1 << b));
    idle();
  endtask
  task automatic put(input logic [31:0] w);
    apb(fifo_host_pkg::ADDR_WDATA, 1'b1, w);
    cmd(fifo_host_pkg::CMD_WR);
  endtask
  task automatic get;
    cmd(fifo_host_pkg::CMD_RD);
    apb(fifo_host_pkg::ADDR_RDATA, 1'b0, 32'h0);
  endtask
  function automatic logic [31:0] flags(input int n);
    return {26'h0, n != D, n < D - 1, n <= D / 2, n > D / 8 && n < D * 7 / 8, n > 1, n != 0};
  endfunction
  function automatic logic [31:0] dat(input int n);
    return 32'((n * 37 + 3) % 512);
  endfunction
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    results();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, d_last} = '0;
    ser_width = 4'h9;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    chk(v[7:0], flags(0));
    apb(fifo_host_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk(v, 32'h0000_0097);
    apb(8'h40, 1'b0, 32'h0);
    chk(32'(er), 32'h0000_0001);
    cmd(fifo_host_pkg::CMD_RD);
    chk(32'(v[fifo_host_pkg::ST_REFUSED]), 32'h0000_0001);
    for (int n = 0; n < D; n++) begin
      put(dat(n));
      chk(v[7:0], flags(n + 1));
    end
    put(32'h0000_0155);
    chk(32'(v[fifo_host_pkg::ST_REFUSED]), 32'h0000_0001);
    for (int n = 0; n < D; n++) begin
      get();
      chk(v, dat(n));
      apb(fifo_host_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk(v[7:0], flags(D - 1 - n));
    end
    ser_width <= 4'h5;
    apb(fifo_host_pkg::ADDR_CTRL, 1'b1, 32'h0000_0056);
    put(32'h0000_0015);
    get();
    chk(v, 32'h0000_0015);
    ser_width <= 4'h9;
    apb(fifo_host_pkg::ADDR_CTRL, 1'b1, 32'h0000_0095);
    put(32'h0000_01a5);
    get();
    chk(v, 32'h0000_01a5);
    put(32'h0000_0033);
    cmd(fifo_host_pkg::CMD_RS);
    chk(v[7:0], flags(0));
    chk(32'(output_enable_n), 32'h0000_0000);
    apb(fifo_host_pkg::ADDR_CTRL, 1'b1, 32'h0000_0093);
    apb(fifo_host_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk(v, 32'h0000_0093);
    chk(32'(er), 32'h0000_0000);
    chk(32'(first_load_or_retransmit), 32'h0000_0000);
    results();
  end
endmodule
